// ### bench/pad_model.sv
/*
  outside circuit at the shared pins: sets the level of every pad the port
  leaves released. assumes pin_out and pin_oe come straight from the port.
*/
module pad_model (
  // port side
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  // outside level
  input  wire logic [15:0] ext_val,
  output logic      [15:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // the port wins where it drives; a released open-drain pad shows ext_val
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule : pad_model

// ### bench/tb_top.sv
/*
  self-checking bench for the shared i/o port: apb master, reference model.
  assumes pad_model closes the pad loop and pready answers in bounded time.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // top pin left out on purpose so absent bits get exercised
  localparam logic [15:0] pm = 16'h7FFF;
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd, rd, r;
  logic [15:0] pin_in, pin_out, pin_oe, pe, pd, po, pi, an_sel, ext;
  logic [15:0] m_dir, m_lat, m_od, m_an, own, drv, e_oe, e_out, e_wire;
  int          fail_count, checked;

  shared_io_port #(.pins_present(pm)) u_shared_io_port (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .periph_enable(pe), .periph_drive(pd), .periph_out(po),
    .periph_in(pi), .analog_sel(an_sel));
  pad_model u_pad_model (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext),
    .pin_level(pin_in));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] nx();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd;
  endfunction : nx

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  // idle edge first so psel never gets two assignments in one time step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // no wait limit here: only the watchdog ends a transfer that never answers
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, rd, e);
    chk("pslverr", {31'h0, er}, 32'h0000_0000);
  endtask : rd_chk

  task automatic pins();
    own    = pe & pd & pm;
    drv    = ~m_dir & ~m_an & ~own & pm;
    e_oe   = own | (drv & ~(m_od & m_lat));
    e_out  = (own & po) | (~own & m_lat);
    e_wire = (e_oe & e_out) | (~e_oe & ext);
    chk("pin_oe", pin_oe, e_oe);
    chk("pin_out", pin_out & e_oe, e_out & e_oe);
    chk("periph_in", pi, e_wire & ~drv & ~m_an & pm);
    chk("analog_sel", an_sel, m_an);
    rd_chk("level", shared_io_pkg::off_level, e_wire & ~m_an & pm);
  endtask : pins

  task automatic regs();
    rd_chk("direction", shared_io_pkg::off_direction, m_dir);
    rd_chk("latch", shared_io_pkg::off_latch, m_lat);
    rd_chk("open_drain", shared_io_pkg::off_open_drain, m_od);
    rd_chk("analog", shared_io_pkg::off_analog, m_an);
    rd_chk("present", shared_io_pkg::off_present, pm);
    pins();
  endtask : regs

  task automatic do_reset(input int cyc);
    rst <= 1'b1;
    repeat (cyc) @(posedge ref_clk);
    rst   <= 1'b0;
    m_dir = pm;
    m_lat = 16'h0000;
    m_od  = 16'h0000;
    m_an  = 16'h0000;
    regs();
  endtask : do_reset

  initial begin
    repeat (8000) @(posedge ref_clk);
    fail_count++;
    complete_run();
  end

  initial begin
    rnd = 32'h0000_0057;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
    paddr   <= 12'h000;
    pwdata  <= 32'h0000_0000;
    {pe, pd, po, ext} <= 64'h0000_0000_0000_0000;
    fail_count = 0;
    checked = 0;
    do_reset(12);
    for (int i = 0; i < 40; i++) begin
      r = nx();
      apb(1'b1, shared_io_pkg::off_direction, r);
      m_dir = r[15:0] & pm;
      r = nx();
      // alternate latch and level writes, both land in the latch
      apb(1'b1, i[0] ? shared_io_pkg::off_level : shared_io_pkg::off_latch, r);
      m_lat = r[15:0] & pm;
      r = nx();
      apb(1'b1, shared_io_pkg::off_open_drain, r);
      m_od = r[15:0] & pm;
      r = nx();
      apb(1'b1, shared_io_pkg::off_analog, r);
      m_an = r[15:0] & pm;
      r = nx();
      pe <= r[15:0];
      pd <= r[31:16];
      r = nx();
      po <= r[15:0];
      ext <= r[31:16];
      // settle time covers the pin synchroniser and the one-cycle read gap
      repeat (6) @(posedge ref_clk);
      regs();
    end
    // analog pins keep direction set; digital outputs clear both bits
    pe <= 16'h0000;
    pd <= 16'h0000;
    apb(1'b1, shared_io_pkg::off_analog, 32'h0000_00F0);
    m_an = 16'h00F0;
    apb(1'b1, shared_io_pkg::off_direction, 32'h0000_00F0);
    m_dir = 16'h00F0;
    apb(1'b1, shared_io_pkg::off_open_drain, 32'h0000_0000);
    m_od = 16'h0000;
    repeat (6) @(posedge ref_clk);
    chk("output_pins", pin_oe, 16'h7F0F);
    chk("output_data", pin_out, m_lat & 16'h7F0F);
    regs();
    apb(1'b1, 12'h018, 32'hFFFF_FFFF);
    chk("pslverr", {31'h0, er}, 32'h0000_0001);
    regs();
    apb(1'b0, 12'h018, 32'h0000_0000);
    chk("unmapped", rd, 32'h0000_0000);
    chk("pslverr", {31'h0, er}, 32'h0000_0001);
    do_reset(2);
    complete_run();
  end
endmodule : tb_top

// ### design/pin_sync.sv
/*
  three-flop synchroniser per pin; a level counts once stages two and three agree.
  assumes pin inputs are asynchronous to ref_clk.
*/
module pin_sync #(
  parameter int width = 16
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // pins in, clean level out
  input  wire logic [width-1:0] pin_async,
  output logic      [width-1:0] pin_clean
);
  logic [width-1:0] s1_r, s2_r, s3_r, clean_r;
  logic [width-1:0] clean_nxt;

  // hold the old level where stages two and three still disagree
  always_comb begin
    clean_nxt = (s2_r & s3_r) | (clean_r & (s2_r | s3_r));
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_r    <= '0;
      s2_r    <= '0;
      s3_r    <= '0;
      clean_r <= '0;
    end else begin
      s1_r    <= pin_async;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      clean_r <= clean_nxt;
    end
  end

  assign pin_clean = clean_r;
endmodule : pin_sync

// ### design/shared_io_pkg.sv
/*
  constants for the shared i/o port slice: register offsets, reset values, widths.
  assumes an apb slave with 32-bit data, one aligned word per register.
*/
package shared_io_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] off_direction  = 12'h000;
  localparam logic [11:0] off_latch      = 12'h004;
  localparam logic [11:0] off_level      = 12'h008;
  localparam logic [11:0] off_open_drain = 12'h00C;
  localparam logic [11:0] off_analog     = 12'h010;
  localparam logic [11:0] off_present    = 12'h014;
  // ----------------------------------------------------------------
  // reset values and widths
  // ----------------------------------------------------------------
  localparam int          data_w         = 32;
  localparam int          port_w         = 16;
  localparam logic [15:0] direction_rst  = 16'hFFFF;
  localparam logic [15:0] latch_rst      = 16'h0000;
  localparam logic [15:0] open_drain_rst = 16'h0000;
  localparam logic [15:0] analog_rst     = 16'h0000;
  localparam logic [15:0] all_pins       = 16'hFFFF;
  localparam logic [15:0] no_pins        = 16'h0000;
  localparam logic [31:0] zero_word      = 32'h0000_0000;
endpackage : shared_io_pkg

// ### design/shared_io_port.sv
/*
  shared i/o port slice: direction, latch, pin level, open-drain and analog
  select per pin, with peripheral ownership muxing, behind an apb slave.
  assumes the pad resolves pin_out/pin_oe into a wire level and returns it on
  pin_in; peripherals present their own data, enable and drive signals.
*/
// Overview of operation
// RQ1: per pin, muxes pick peripheral or port for output data and enable.
// RQ2: port output value never reaches the sharing peripheral's input.
// RQ3: enabled driving peripheral disables port driver; pin stays readable.
// RQ4: enabled but idle peripheral lets the port drive the pin.
// RQ5: direction bit one means input, zero means output.
// RQ6: every reset makes all pins inputs.
// RQ7: latch register reads stored latch; writes update latch.
// RQ8: level register reads pin levels; writes go to the latch toward pins.
// RQ9: unimplemented bits read zero in latch, direction, level; no effect.
// RQ10: software waits one cycle after a write before reading the port.
// RQ11: open-drain bit set: drive low only, release instead of high.
// RQ12: analog select one picks analog, zero digital under direction bit.
// RQ13: analog-input pins read zero in the level register.
// RQ14: software waits one cycle after making a pin digital input.
// RQ15: analog output pins should keep direction bit one.
// RQ16: digital output needs analog and direction clear, analog output off.
// RQ17: unowned digital output drives from latch, honouring open drain.
module shared_io_port #(
  parameter int          port_w      = shared_io_pkg::port_w,
  parameter logic [15:0] pins_present = shared_io_pkg::all_pins
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic      [31:0]       prdata,
  output logic                   pslverr,
  // pads
  input  wire logic [port_w-1:0] pin_in,
  output logic      [port_w-1:0] pin_out,
  output logic      [port_w-1:0] pin_oe,
  // sharing peripherals
  input  wire logic [port_w-1:0] periph_enable,
  input  wire logic [port_w-1:0] periph_drive,
  input  wire logic [port_w-1:0] periph_out,
  output logic      [port_w-1:0] periph_in,
  // analog side
  output logic      [port_w-1:0] analog_sel
);
  localparam logic [port_w-1:0] present = pins_present[port_w-1:0];

  logic [port_w-1:0] dir_r, dir_nxt;
  logic [port_w-1:0] lat_r, lat_nxt;
  logic [port_w-1:0] odc_r, odc_nxt;
  logic [port_w-1:0] ans_r, ans_nxt;
  logic [31:0]       rdata_r, rdata_nxt;
  logic              err_r, err_nxt;
  logic [port_w-1:0] pin_clean;
  logic [port_w-1:0] owned, port_drive, port_oe, port_val, level_view;
  logic              wr_acc, rd_acc, mapped;

  // bits above the port width always read as zero
  function automatic logic [31:0] widen(input logic [port_w-1:0] v);
    widen = {{(shared_io_pkg::data_w - port_w){1'b0}}, v};
  endfunction : widen

  // ----------------------------------------------------------------
  // pin input path
  // ----------------------------------------------------------------
  pin_sync #(
    .width     (port_w)
  ) u_sync (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .pin_async (pin_in),
    .pin_clean (pin_clean)
  );

  // the synchroniser makes level reads trail the pad by about four cycles
  // analog inputs read low; absent bits read low
  assign level_view = pin_clean & ~ans_r & present; // see RQ13 // see RQ9

  // ----------------------------------------------------------------
  // output muxes
  // ----------------------------------------------------------------
  // one enable/drive pair per pin, so ownership needs no priority; absent pins ignore it
  assign owned      = periph_enable & periph_drive & present; // see RQ3 // see RQ4
  // port drives only digital outputs that no peripheral owns
  assign port_drive = ~dir_r & ~ans_r & ~owned & present; // see RQ5 // see RQ12 // see RQ17
  // open drain: a one releases the pin instead of driving high
  assign port_oe    = port_drive & ~(odc_r & lat_r); // see RQ11
  assign port_val   = lat_r & ~odc_r;
  always_comb begin
    for (int i = 0; i < port_w; i++) begin
      pin_oe[i]  = owned[i] ? 1'b1 : port_oe[i]; // see RQ1
      pin_out[i] = owned[i] ? periph_out[i] : (port_oe[i] & port_val[i]); // see RQ1
    end
  end
  // peripheral sees the real pin level, gated off where the port drives it
  assign periph_in  = pin_clean & ~port_drive & ~ans_r & present; // see RQ2 // see RQ9
  assign analog_sel = ans_r & present; // see RQ12

  // ----------------------------------------------------------------
  // apb register file
  // ----------------------------------------------------------------
  assign wr_acc  = psel & penable & pwrite;
  assign rd_acc  = psel & ~penable & ~pwrite;
  // every register answers at once, so no wait states are ever inserted
  assign pready  = 1'b1;
  assign pslverr = err_r;
  assign prdata  = rdata_r;

  // this decode feeds only the error path; write and read cases decode paddr themselves
  always_comb begin
    mapped = 1'b1;
    unique case (paddr)
      shared_io_pkg::off_direction,
      shared_io_pkg::off_latch,
      shared_io_pkg::off_level,
      shared_io_pkg::off_open_drain,
      shared_io_pkg::off_analog,
      shared_io_pkg::off_present: mapped = 1'b1;
      default:                    mapped = 1'b0;
    endcase
  end

  always_comb begin
    dir_nxt   = dir_r;
    lat_nxt   = lat_r;
    odc_nxt   = odc_r;
    ans_nxt   = ans_r;
    rdata_nxt = rdata_r;
    // an unmapped setup registers an error that stands through the access phase
    err_nxt   = psel & ~penable & ~mapped;
    if (wr_acc) begin
      unique case (paddr)
        shared_io_pkg::off_direction:  dir_nxt = pwdata[port_w-1:0] & present; // see RQ5
        shared_io_pkg::off_latch:      lat_nxt = pwdata[port_w-1:0] & present; // see RQ7
        shared_io_pkg::off_level:      lat_nxt = pwdata[port_w-1:0] & present; // see RQ8
        shared_io_pkg::off_open_drain: odc_nxt = pwdata[port_w-1:0] & present; // see RQ11
        shared_io_pkg::off_analog:     ans_nxt = pwdata[port_w-1:0] & present; // see RQ12
        default:                       ; // read-only or unmapped: write ignored
      endcase
    end
    // read data is captured in setup so it is registered by the access phase
    if (rd_acc) begin
      unique case (paddr)
        // absent bits are held as inputs inside but read back as zero
        shared_io_pkg::off_direction:  rdata_nxt = widen(dir_r & present); // see RQ9
        shared_io_pkg::off_latch:      rdata_nxt = widen(lat_r); // see RQ7
        shared_io_pkg::off_level:      rdata_nxt = widen(level_view); // see RQ8
        shared_io_pkg::off_open_drain: rdata_nxt = widen(odc_r);
        shared_io_pkg::off_analog:     rdata_nxt = widen(ans_r);
        shared_io_pkg::off_present:    rdata_nxt = widen(present);
        default:                       rdata_nxt = shared_io_pkg::zero_word;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dir_r   <= shared_io_pkg::direction_rst; // see RQ6
      lat_r   <= shared_io_pkg::latch_rst;
      odc_r   <= shared_io_pkg::open_drain_rst;
      ans_r   <= shared_io_pkg::analog_rst;
      rdata_r <= shared_io_pkg::zero_word;
      err_r   <= 1'b0;
    end else begin
      // absent pins stay inputs so they can never drive a pad
      dir_r   <= dir_nxt | ~present;
      lat_r   <= lat_nxt;
      odc_r   <= odc_nxt;
      ans_r   <= ans_nxt;
      rdata_r <= rdata_nxt;
      err_r   <= err_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pin checks
  // ----------------------------------------------------------------
  function automatic logic [port_w-1:0] no_sig();
    no_sig = '0;
  endfunction : no_sig

  property p_owner_drives;
    @(posedge ref_clk) disable iff (rst)
      owned != no_sig() |-> ((pin_oe & owned) == owned) && ((pin_out & owned) == (periph_out & owned));
  endproperty
  a_owner_drives: assert property (p_owner_drives) else $error("peripheral lost its pin"); // see RQ1

  property p_no_loop;
    @(posedge ref_clk) disable iff (rst)
      (periph_in & port_drive) == no_sig();
  endproperty
  a_no_loop: assert property (p_no_loop) else $error("port output loops into peripheral"); // see RQ2

  property p_idle_periph;
    @(posedge ref_clk) disable iff (rst)
      ((periph_enable & ~periph_drive & ~dir_r & ~ans_r & ~odc_r & present & lat_r)
        & ~(pin_oe & pin_out)) == no_sig();
  endproperty
  a_idle_periph: assert property (p_idle_periph) else $error("idle peripheral blocks port"); // see RQ4

  property p_input_released;
    @(posedge ref_clk) disable iff (rst)
      ((dir_r & ~owned) & pin_oe) == no_sig();
  endproperty
  a_input_released: assert property (p_input_released) else $error("input pin driven"); // see RQ5

  property p_reset_inputs;
    @(posedge ref_clk) $fell(rst) |-> dir_r == {port_w{1'b1}} && (pin_oe & ~owned) == no_sig();
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) else $error("pins not inputs after reset"); // see RQ6

  property p_latch_write;
    @(posedge ref_clk) disable iff (rst)
      wr_acc && (paddr == shared_io_pkg::off_latch || paddr == shared_io_pkg::off_level)
      |=> lat_r == ($past(pwdata[port_w-1:0]) & present);
  endproperty
  a_latch_write: assert property (p_latch_write) else $error("latch not written"); // see RQ7

  property p_latch_read;
    @(posedge ref_clk) disable iff (rst)
      rd_acc && paddr == shared_io_pkg::off_latch |=> prdata == widen(lat_r);
  endproperty
  a_latch_read: assert property (p_latch_read) else $error("latch read wrong"); // see RQ7

  property p_open_drain;
    @(posedge ref_clk) disable iff (rst)
      ((odc_r & ~owned) & pin_oe & pin_out) == no_sig();
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drove high"); // see RQ11

  property p_analog_low;
    @(posedge ref_clk) disable iff (rst)
      rd_acc && paddr == shared_io_pkg::off_level |=> (prdata[port_w-1:0] & $past(ans_r)) == no_sig();
  endproperty
  a_analog_low: assert property (p_analog_low) else $error("analog pin read high"); // see RQ13

  property p_absent;
    @(posedge ref_clk) disable iff (rst)
      ((pin_oe | lat_r | odc_r | ans_r | periph_in) & ~present) == no_sig();
  endproperty
  a_absent: assert property (p_absent) else $error("absent bit active"); // see RQ9

  property p_digital_out;
    @(posedge ref_clk) disable iff (rst)
      ((port_drive & ~odc_r) & ~(pin_oe & ~(pin_out ^ lat_r))) == no_sig();
  endproperty
  a_digital_out: assert property (p_digital_out) else $error("pin does not follow latch"); // see RQ17

  property p_out_driven;
    @(posedge ref_clk) disable iff (rst)
      (~dir_r & ~ans_r & ~owned & present & ~(odc_r & lat_r) & ~pin_oe) == no_sig();
  endproperty
  a_out_driven: assert property (p_out_driven) else $error("output not driven"); // see RQ5

  property p_od_low;
    @(posedge ref_clk) disable iff (rst)
      ((port_drive & odc_r & ~lat_r) & ~(pin_oe & ~pin_out)) == no_sig();
  endproperty
  a_od_low: assert property (p_od_low) else $error("open drain did not pull low"); // see RQ11

  property p_analog_free;
    @(posedge ref_clk) disable iff (rst)
      (analog_sel & pin_oe & ~owned) == no_sig();
  endproperty
  a_analog_free: assert property (p_analog_free) else $error("analog pin driven"); // see RQ12

  // ----------------------------------------------------------------
  // register read and reset checks, and covers
  // ----------------------------------------------------------------
  property p_dir_read;
    @(posedge ref_clk) disable iff (rst)
      rd_acc && paddr == shared_io_pkg::off_direction
      |=> prdata == widen($past(dir_r) & present);
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction read wrong"); // see RQ9

  property p_owned_read;
    @(posedge ref_clk) disable iff (rst)
      rd_acc && paddr == shared_io_pkg::off_level
      |=> ((prdata[port_w-1:0] ^ $past(pin_clean)) & $past(owned & ~ans_r)) == no_sig();
  endproperty
  a_owned_read: assert property (p_owned_read) else $error("owned pin not read"); // see RQ3

  property p_reset_regs;
    @(posedge ref_clk)
      rst |=> dir_r == {port_w{1'b1}} && lat_r == no_sig()
              && odc_r == no_sig() && ans_r == no_sig();
  endproperty
  a_reset_regs: assert property (p_reset_regs) else $error("registers not reset"); // see RQ6

  c_write: cover property (@(posedge ref_clk) wr_acc && paddr == shared_io_pkg::off_direction);
  c_owned: cover property (@(posedge ref_clk) owned != no_sig());
  c_od:    cover property (@(posedge ref_clk) (odc_r & port_drive) != no_sig());
  c_err:   cover property (@(posedge ref_clk) pslverr);
  c_analog: cover property (@(posedge ref_clk) analog_sel != no_sig());
endmodule : shared_io_port
